// ### pbsc_pkg.sv
// Constants, register map and types for the panelless bus strobe control block
`default_nettype none
package pbsc_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [3:0] PBSC_CTRL_OFS = 4'h0;
  localparam logic [3:0] PBSC_STATUS_OFS = 4'h4;
  localparam logic [3:0] PBSC_VECTOR_OFS = 4'h8;
  localparam int PBSC_ADDR_W = 4;
  // Control register fields and reset value
  localparam int PBSC_CTRL_STROBE_BIT = 0;
  localparam int PBSC_CTRL_PANEL_BIT = 1;
  localparam logic [1:0] PBSC_CTRL_RESET = 2'h3;
  // Status register fields
  localparam int PBSC_STAT_STROBE_BIT = 0;
  localparam int PBSC_STAT_PANEL_BIT = 1;
  localparam int PBSC_STAT_JUMP_BIT = 2;
  localparam int PBSC_STAT_DMA_BIT = 3;
  localparam int PBSC_STAT_RUN_BIT = 4;
  // Start location geometry: PROM address jumpers pick a 1 K boundary
  localparam int PBSC_CPU_ADDR_W = 16;
  localparam int PBSC_PAGE_SHIFT = 10;
  localparam int PBSC_PAGE_W = PBSC_CPU_ADDR_W - PBSC_PAGE_SHIFT;
  localparam logic [15:0] PBSC_ZERO_VECTOR = 16'h0000;
  // Strap reset value: strobe generation off until straps are sampled
  localparam logic PBSC_STRAP_RESET = 1'b0;
  // AXI responses
  localparam logic [1:0] PBSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PBSC_RESP_SLVERR = 2'h2;
  // Reset sequencer states, Gray along hold -> run
  typedef enum logic {PBSC_HOLD = 1'b0, PBSC_RUN = 1'b1} pbsc_seq_type;
endpackage
`default_nettype wire

// ### pbsc_boot_if.sv
// Interface between the top and the start-up sequencer
`timescale 1ns/1ns
`default_nettype none
interface pbsc_boot_if;
  import pbsc_pkg::*;
  logic ext_reset;
  logic jump_enable;
  logic prom_enable;
  logic [PBSC_PAGE_W-1:0] prom_page;
  logic [PBSC_CPU_ADDR_W-1:0] start_vector;
  logic cpu_reset_n;
  logic jump_taken;
  logic running;
  modport ctl (output ext_reset, jump_enable, prom_enable, prom_page,
    input start_vector, cpu_reset_n, jump_taken, running);
  modport seq (input ext_reset, jump_enable, prom_enable, prom_page,
    output start_vector, cpu_reset_n, jump_taken, running);
endinterface
`default_nettype wire

// ### pbsc_boot_seq.sv
// Start-up sequencer: holds the processor in reset and picks its start location
`timescale 1ns/1ns
`default_nettype none
module pbsc_boot_seq
  import pbsc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  pbsc_boot_if.seq boot
);
  pbsc_seq_type state_reg, state_next;
  logic [PBSC_CPU_ADDR_W-1:0] vector_reg, vector_next;
  logic jump_reg, jump_next;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: vector follows the switches while reset is held
  always_comb
  begin
    state_next = state_reg;
    vector_next = vector_reg;
    jump_next = jump_reg;
    unique case (state_reg)
      PBSC_HOLD:
      begin
        // Same jumpers place the PROM or the main-memory target
        if (boot.jump_enable)
        begin
          vector_next = {boot.prom_page, {PBSC_PAGE_SHIFT{1'b0}}}; // [RL9] [RL10]
        end
        else
        begin
          vector_next = PBSC_ZERO_VECTOR; // [RL11]
        end
        jump_next = boot.jump_enable;
        if (!boot.ext_reset)
        begin
          state_next = PBSC_RUN;
        end
      end
      PBSC_RUN:
      begin
        // Switch changes after release have no effect until next reset
        if (boot.ext_reset)
        begin
          state_next = PBSC_HOLD; // [RL8]
        end
      end
    endcase
  end

  // Registers only
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= PBSC_HOLD;
      vector_reg <= PBSC_ZERO_VECTOR;
      jump_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      vector_reg <= vector_next;
      jump_reg <= jump_next;
    end
  end

  assign boot.start_vector = vector_reg;
  assign boot.jump_taken = jump_reg;
  assign boot.running = (state_reg == PBSC_RUN);
  assign boot.cpu_reset_n = (state_reg == PBSC_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_hold_with_jump;
    (state_reg == PBSC_HOLD) && boot.jump_enable;
  endsequence
  sequence s_hold_no_jump;
    (state_reg == PBSC_HOLD) && !boot.jump_enable;
  endsequence

  chk_jump_vector: assert property (@(posedge clock) disable iff (!rst_n) // [RL9]
    s_hold_with_jump |=> boot.start_vector == {$past(boot.prom_page), 10'h000} && boot.jump_taken)
    else $error("jump vector not taken from prom page");
  chk_zero_vector: assert property (@(posedge clock) disable iff (!rst_n) // [RL11]
    s_hold_no_jump |=> boot.start_vector == 16'h0000 && !boot.jump_taken)
    else $error("start vector not zero without jump enable");
  chk_ext_reset_hold: assert property (@(posedge clock) disable iff (!rst_n) // [RL8]
    boot.ext_reset |=> !boot.cpu_reset_n)
    else $error("processor not held in reset");
  chk_vector_stable: assert property (@(posedge clock) disable iff (!rst_n) // [RL10]
    boot.running && !boot.ext_reset |=> $stable(boot.start_vector))
    else $error("start vector changed while running");
endmodule
`default_nettype wire

// ### pbsc_top.sv
// Panelless bus strobe control: write strobe, panel line gating, boot and registers
`timescale 1ns/1ns
`default_nettype none
//
// Overview of operation
// [RL1] With generation selected, drive the bus write strobe for processor memory writes.
// [RL2] With generation selected, also drive the strobe for DMA master memory writes.
// [RL3] A static select input enables or disables the write strobe generator.
// [RL4] Integrator keeps generation off whenever a front panel supplies the strobe.
// [RL5] Strobe generation is off by default until enabled.
// [RL6] A select input connects or cuts off the two legacy panel lines.
// [RL7] Integrator should cut off the panel lines in panelless systems.
// [RL8] Header reset and jump enable inputs control processor start-up.
// [RL9] Jump enabled with PROM enabled starts at the PROM base address.
// [RL10] Jump enabled with PROM disabled starts at the jumper-set main memory address.
// [RL11] Jump disabled starts execution at address zero.
// [RL12] With generation off the strobe line is left undriven.
module pbsc_top
  import pbsc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic write_strobe_gen_select,
  input wire logic panel_line_connect_select,
  input wire logic cpu_mem_write,
  input wire logic dma_active,
  input wire logic dma_mem_write,
  output logic mwrt_out,
  output logic mwrt_oe_n,
  input wire logic data_in_disable_in,
  input wire logic sense_switch_disable_in,
  output logic data_in_block,
  output logic sense_switch_block,
  input wire logic ext_reset_in,
  input wire logic jump_enable_in,
  input wire logic prom_enable_select,
  input wire logic [PBSC_PAGE_W-1:0] prom_page_select,
  output logic cpu_reset_n,
  output logic [PBSC_CPU_ADDR_W-1:0] start_vector,
  input wire logic [PBSC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [PBSC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  pbsc_boot_if boot ();

  logic strobe_strap_reg, strobe_strap_next;
  logic panel_strap_reg, panel_strap_next;
  logic [1:0] ctrl_reg, ctrl_next;
  logic mwrt_reg, mwrt_next;
  logic drive_reg, drive_next;
  logic din_blk_reg, din_blk_next;
  logic ssw_blk_reg, ssw_blk_next;
  logic gen_en, panel_en;
  logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [PBSC_ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic wstrb0_reg, wstrb0_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic first_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Start-up sequencer
  assign boot.ext_reset = ext_reset_in;
  assign boot.jump_enable = jump_enable_in;
  assign boot.prom_enable = prom_enable_select;
  assign boot.prom_page = prom_page_select;

  pbsc_boot_seq u_seq (
    .clock(clock),
    .rst_n(rst_n),
    .boot(boot)
  );

  assign cpu_reset_n = boot.cpu_reset_n; // [RL8]
  assign start_vector = boot.start_vector;

  ////////////////////////////////////////////////////////////////////////////
  // Strap sampling and bus-facing outputs
  // Straps are read after release, never loaded during async reset
  assign gen_en = strobe_strap_reg && ctrl_reg[PBSC_CTRL_STROBE_BIT]; // [RL3] [RL5]
  assign panel_en = panel_strap_reg && ctrl_reg[PBSC_CTRL_PANEL_BIT];

  always_comb
  begin
    strobe_strap_next = write_strobe_gen_select; // [RL3]
    panel_strap_next = panel_line_connect_select;
    // Processor writes or a DMA master's writes while it owns the bus
    mwrt_next = gen_en && (cpu_mem_write || (dma_active && dma_mem_write)); // [RL1] [RL2]
    drive_next = gen_en; // [RL12]
    // Cut-off lines read as inactive so nothing downstream reacts
    din_blk_next = panel_en && data_in_disable_in; // [RL6]
    ssw_blk_next = panel_en && sense_switch_disable_in; // [RL6]
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strobe_strap_reg <= PBSC_STRAP_RESET;
      panel_strap_reg <= PBSC_STRAP_RESET;
      mwrt_reg <= 1'b0;
      drive_reg <= 1'b0;
      din_blk_reg <= 1'b0;
      ssw_blk_reg <= 1'b0;
    end
    else
    begin
      strobe_strap_reg <= strobe_strap_next;
      panel_strap_reg <= panel_strap_next;
      mwrt_reg <= mwrt_next;
      drive_reg <= drive_next;
      din_blk_reg <= din_blk_next;
      ssw_blk_reg <= ssw_blk_next;
    end
  end

  assign mwrt_out = mwrt_reg;
  assign mwrt_oe_n = !drive_reg; // [RL12]
  assign data_in_block = din_blk_reg;
  assign sense_switch_block = ssw_blk_reg;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave; address and data taken in either order
  assign s_axi_awready = !aw_got_reg && !bvalid_reg;
  assign s_axi_wready = !w_got_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;

  always_comb
  begin
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb0_next = wstrb0_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    ctrl_next = ctrl_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_got_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb0_next = s_axi_wstrb[0];
    end
    // Commit one cycle after both halves are held
    if (aw_got_reg && w_got_reg)
    begin
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = PBSC_RESP_OKAY;
      if (awaddr_reg == PBSC_CTRL_OFS)
      begin
        if (wstrb0_reg)
        begin
          ctrl_next = wdata_reg[1:0];
        end
      end
      else if (awaddr_reg != PBSC_STATUS_OFS && awaddr_reg != PBSC_VECTOR_OFS)
      begin
        bresp_next = PBSC_RESP_SLVERR;
      end
    end
    if (bvalid_reg && s_axi_bready)
    begin
      bvalid_next = 1'b0;
    end
    // Read data captured at address acceptance
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_next = 1'b1;
      rresp_next = PBSC_RESP_OKAY;
      rdata_next = 32'h0000_0000;
      unique case (s_axi_araddr)
        PBSC_CTRL_OFS: rdata_next[1:0] = ctrl_reg;
        PBSC_STATUS_OFS:
        begin
          rdata_next[PBSC_STAT_STROBE_BIT] = drive_reg;
          rdata_next[PBSC_STAT_PANEL_BIT] = panel_en;
          rdata_next[PBSC_STAT_JUMP_BIT] = boot.jump_taken;
          rdata_next[PBSC_STAT_DMA_BIT] = dma_active;
          rdata_next[PBSC_STAT_RUN_BIT] = boot.running;
        end
        PBSC_VECTOR_OFS: rdata_next[PBSC_CPU_ADDR_W-1:0] = boot.start_vector;
        default: rresp_next = PBSC_RESP_SLVERR;
      endcase
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= PBSC_RESP_OKAY;
      ctrl_reg <= PBSC_CTRL_RESET;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= PBSC_RESP_OKAY;
    end
    else
    begin
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb0_reg <= wstrb0_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      ctrl_reg <= ctrl_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Marks the first clock after reset release
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      first_reg <= 1'b1;
    end
    else
    begin
      first_reg <= 1'b0;
    end
  end

  chk_cpu_strobe: assert property (@(posedge clock) disable iff (!rst_n) // [RL1]
    gen_en && cpu_mem_write |=> mwrt_out && !mwrt_oe_n)
    else $error("processor write gave no strobe");
  chk_dma_strobe: assert property (@(posedge clock) disable iff (!rst_n) // [RL2]
    gen_en && dma_active && dma_mem_write |=> mwrt_out && !mwrt_oe_n)
    else $error("dma write gave no strobe");
  chk_strap_off: assert property (@(posedge clock) disable iff (!rst_n) // [RL3]
    !write_strobe_gen_select ##1 1'b1 |=> mwrt_oe_n && !mwrt_out)
    else $error("strobe driven with select off");
  chk_default_off: assert property (@(posedge clock) disable iff (!rst_n) // [RL5]
    first_reg |-> mwrt_oe_n && !gen_en)
    else $error("strobe enabled straight after reset");
  chk_panel_cut: assert property (@(posedge clock) disable iff (!rst_n) // [RL6]
    !panel_en |=> !data_in_block && !sense_switch_block)
    else $error("panel line passed while cut off");
  chk_undriven_low: assert property (@(posedge clock) disable iff (!rst_n) // [RL12]
    mwrt_oe_n |-> !mwrt_out)
    else $error("strobe active while undriven");
endmodule
`default_nettype wire

// ### pbsc_bus_model.sv
// Far-side bus model: front panel, strobe line resolution and legacy panel lines
`timescale 1ns/1ns
`default_nettype none
module pbsc_bus_model
(
  input wire logic clock,
  input wire logic mwrt_out,
  input wire logic mwrt_oe_n,
  input wire logic panel_present,
  input wire logic panel_deposit,
  input wire logic panel_ctl,
  output logic mwrt_line,
  output logic conflict,
  output logic data_in_disable_line,
  output logic sense_switch_disable_line
);
  logic noise_reg = 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  // Free-running pattern stands in for a floating line, so no stale value passes
  always @(posedge clock)
  begin
    noise_reg <= ~noise_reg;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Strobe line: board driver, else panel, else nobody
  always_comb
  begin
    if (!mwrt_oe_n)
      mwrt_line = mwrt_out;
    else if (panel_present)
      mwrt_line = panel_deposit;
    else
      mwrt_line = noise_reg;
  end
  // Two drivers at once would fight on the bus
  assign conflict = !mwrt_oe_n && panel_present;
  // Panel lines float when no panel is fitted
  assign data_in_disable_line = panel_present ? panel_ctl : noise_reg;
  assign sense_switch_disable_line = panel_present ? panel_ctl : ~noise_reg;
endmodule
`default_nettype wire

// ### pbsc_top_test.sv
// Self-checking testbench for the panelless bus strobe control block
`timescale 1ns/1ns
`default_nettype none
module pbsc_top_test;
  import pbsc_pkg::*;
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
  logic clock, rst_n, write_strobe_gen_select, panel_line_connect_select;
  logic cpu_mem_write, dma_active, dma_mem_write, mwrt_out, mwrt_oe_n;
  logic data_in_block, sense_switch_block, ext_reset_in, jump_enable_in;
  logic prom_enable_select, cpu_reset_n;
  logic [PBSC_PAGE_W-1:0] prom_page_select;
  logic [PBSC_CPU_ADDR_W-1:0] start_vector;
  logic [PBSC_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] rd;
  logic panel_present, panel_deposit, panel_ctl, mwrt_line, conflict;
  wire logic data_in_disable_in, sense_switch_disable_in;
  logic [15:0] exp_vec;
  int failures = 0;
  int compares = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // Design, far-side model and clock
  pbsc_top dut_u (.clock, .rst_n, .write_strobe_gen_select, .panel_line_connect_select,
    .cpu_mem_write, .dma_active, .dma_mem_write, .mwrt_out, .mwrt_oe_n,
    .data_in_disable_in, .sense_switch_disable_in, .data_in_block, .sense_switch_block,
    .ext_reset_in, .jump_enable_in, .prom_enable_select, .prom_page_select, .cpu_reset_n,
    .start_vector, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  pbsc_bus_model bus_u (.clock, .mwrt_out, .mwrt_oe_n, .panel_present, .panel_deposit,
    .panel_ctl, .mwrt_line, .conflict, .data_in_disable_line(data_in_disable_in),
    .sense_switch_disable_line(sense_switch_disable_in));
  always #10 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////////
  // Bus tasks; readies sampled mid-cycle, where they are settled for the next edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    bit aw_hit, w_hit, b_hit;
    int n;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(negedge clock);
      aw_hit = s_axi_awvalid && s_axi_awready;
      w_hit = s_axi_wvalid && s_axi_wready;
      b_hit = s_axi_bvalid && s_axi_bready;
      resp = s_axi_bresp;
      @(posedge clock);
      if (aw_hit) s_axi_awvalid <= 1'b0;
      if (w_hit) s_axi_wvalid <= 1'b0;
      n++;
    end
    while (!b_hit && n < 200);
    // A response that never comes counts as a mismatch
    if (!b_hit) failures++;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    bit ar_hit, r_hit;
    int n;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(negedge clock);
      ar_hit = s_axi_arvalid && s_axi_arready;
      r_hit = s_axi_rvalid && s_axi_rready;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clock);
      if (ar_hit) s_axi_arvalid <= 1'b0;
      n++;
    end
    while (!r_hit && n < 200);
    if (!r_hit) failures++;
    s_axi_rready <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog: the tests need well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge clock);
    failures++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; starts as a front panel system with both straps off
  initial
  begin
    {clock, rst_n, write_strobe_gen_select, panel_line_connect_select} = 4'h0;
    {cpu_mem_write, dma_active, dma_mem_write, jump_enable_in, prom_enable_select} = 5'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 44'h0;
    {panel_present, panel_deposit, panel_ctl, ext_reset_in} = 4'hD;
    prom_page_select = 6'h00;
    tick(8);
    rst_n <= 1'b1;
    tick(4);
    `CHK(mwrt_oe_n, 1'b1)
    `CHK(cpu_reset_n, 1'b0)
    axi_rd(PBSC_CTRL_OFS);
    `CHK(rd, {30'h0, PBSC_CTRL_RESET})
    $display("test reset_defaults done");
    // Strap off: panel alone owns the strobe line
    cpu_mem_write <= 1'b1;
    panel_deposit <= 1'b1;
    tick(4);
    `CHK(mwrt_oe_n, 1'b1)
    `CHK(mwrt_line, 1'b1)
    `CHK(conflict, 1'b0)
    $display("test strap_off done");
    // Panel removed, generation on: processor and DMA writes
    panel_present <= 1'b0;
    write_strobe_gen_select <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      {cpu_mem_write, dma_active, dma_mem_write} <= 3'(12'o4310 >> (3 * i));
      tick(4);
      `CHK(mwrt_oe_n, 1'b0)
      `CHK(mwrt_line, (i == 2 || i == 3))
      `CHK(conflict, 1'b0)
    end
    $display("test strobe_gen done");
    // Register gate on generation, and a byte-masked write that must be ignored
    cpu_mem_write <= 1'b1;
    axi_wr(PBSC_CTRL_OFS, 32'h0000_0002, 4'hF);
    `CHK(resp, PBSC_RESP_OKAY)
    tick(4);
    `CHK(mwrt_oe_n, 1'b1)
    axi_wr(PBSC_CTRL_OFS, 32'h0000_0003, 4'h0);
    axi_rd(PBSC_CTRL_OFS);
    `CHK(rd, 32'h0000_0002)
    axi_wr(PBSC_CTRL_OFS, 32'h0000_0003, 4'hF);
    tick(4);
    `CHK(mwrt_line, 1'b1)
    cpu_mem_write <= 1'b0;
    write_strobe_gen_select <= 1'b0;
    $display("test ctrl_gate done");
    // Legacy panel lines cut off, then connected; panel fitted once our driver is off
    tick(3);
    `CHK(mwrt_oe_n, 1'b1)
    panel_present <= 1'b1;
    panel_ctl <= 1'b1;
    tick(4);
    `CHK({data_in_block, sense_switch_block}, 2'b00)
    panel_line_connect_select <= 1'b1;
    tick(4);
    `CHK({data_in_block, sense_switch_block}, 2'b11)
    panel_ctl <= 1'b0;
    tick(4);
    `CHK({data_in_block, sense_switch_block}, 2'b00)
    $display("test panel_lines done");
    // Every boot switch and PROM strap combination
    for (int i = 0; i < 4; i++)
    begin
      ext_reset_in <= 1'b1;
      jump_enable_in <= i[1];
      prom_enable_select <= i[0];
      prom_page_select <= 6'(6'h3C + i);
      exp_vec = i[1] ? {6'(6'h3C + i), 10'h000} : PBSC_ZERO_VECTOR;
      tick(3);
      `CHK(cpu_reset_n, 1'b0)
      ext_reset_in <= 1'b0;
      tick(3);
      `CHK(cpu_reset_n, 1'b1)
      `CHK(start_vector, exp_vec)
      axi_rd(PBSC_VECTOR_OFS);
      `CHK(rd, {16'h0, exp_vec})
    end
    // Running, jump taken and panel connected; strap off so strobe bit clear
    exp_vec = 16'((1 << PBSC_STAT_PANEL_BIT) | (1 << PBSC_STAT_JUMP_BIT)
      | (1 << PBSC_STAT_RUN_BIT));
    axi_rd(PBSC_STATUS_OFS);
    `CHK(rd, {16'h0, exp_vec})
    $display("test boot_vector done");
    // Unmapped word
    axi_wr(4'hC, 32'hFFFF_FFFF, 4'hF);
    `CHK(resp, PBSC_RESP_SLVERR)
    axi_rd(4'hC);
    `CHK({resp, rd}, {PBSC_RESP_SLVERR, 32'h0})
    $display("test unmapped done");
    report_and_stop();
  end
endmodule
`default_nettype wire
